// File: design/pbw_pkg.sv
// power button and wake manager: shared constants, map and types
// assumes a 25 MHz standby clock and an APB slave with 8-bit addresses
package pbw_pkg;

    // --------------------------------------------------------------
    // power states
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_S0 = 3'b000,
        ST_S1 = 3'b001,
        ST_S3 = 3'b011,
        ST_S4 = 3'b100,
        ST_S5 = 3'b101
    } pbw_state_t;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned LONG_PRESS_S = 4;
    localparam int unsigned LONG_CYC     = LONG_PRESS_S * CLK_HZ;
    localparam int unsigned DEB_MS       = 20;
    localparam int unsigned DEB_CYC      = DEB_MS * (CLK_HZ / 1000);

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CMD   = 8'h04;
    localparam logic [7:0] ADDR_RMT   = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam logic [7:0] ADDR_ISTAT = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;
    localparam logic [7:0] ADDR_FW    = 8'h18;
    localparam logic [7:0] ADDR_VFLT  = 8'h1C;
    localparam logic [7:0] ADDR_FAN   = 8'h20;
    localparam logic [7:0] ADDR_VLIM0 = 8'h24;
    localparam logic [7:0] ADDR_VLIMN = 8'h34;

    // --------------------------------------------------------------
    // fields and reset values
    // --------------------------------------------------------------
    localparam int CTRL_S5EN   = 0;
    localparam int CTRL_SLP    = 1;
    localparam int RMT_RESET   = 0;
    localparam int RMT_SHUT    = 1;
    localparam int RMT_CYCLE   = 2;
    localparam int RMT_UP      = 3;
    localparam int I_INTR      = 0;
    localparam int I_VOLT      = 1;
    localparam int I_PROG      = 2;
    localparam int I_ERR       = 3;
    localparam int I_WAKE      = 4;
    localparam int I_LONG      = 5;
    localparam int FW_ERR      = 8;
    localparam int ST_PEND     = 3;
    localparam int ST_PWR      = 4;
    localparam logic [2:0]  CTRL_RST  = 3'h2;
    localparam logic [5:0]  IMASK_RST = 6'h00;
    localparam logic [15:0] FAN_RST   = 16'hC040;
    localparam logic [15:0] VLIM_RST  = 16'hFF00;

    // wake inputs: lan, pme, rtc, pcie, modem, ps2, usb
    localparam logic [6:0] WAKE_DEEP  = 7'h0F;
    localparam logic [6:0] WAKE_S5    = 7'h0C;
    localparam logic [6:0] WAKE_GATED = 7'h03;

endpackage

// File: design/pbw_press_if.sv
// press decisions handed from the switch timer to the sequencer
// both ends run on the standby clock
`timescale 1ns/1ps
interface pbw_press_if;
    logic short_p;
    logic long_p;
    modport src (output short_p, output long_p);
    modport dst (input short_p, input long_p);
endinterface

// File: design/pbw_press.sv
// power switch debounce and press duration timer
// assumes the switch level is already synchronous to clk
`timescale 1ns/1ps
module pbw_press #(
    parameter int unsigned DEB_CYC  = pbw_pkg::DEB_CYC,
    parameter int unsigned LONG_CYC = pbw_pkg::LONG_CYC
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    // switch and decisions
    input  wire logic   pwr_btn_b,
    pbw_press_if.src    press
);

    logic [31:0] deb_cnt_q;
    logic [31:0] hold_cnt_q;
    logic        pressed_q;

    // --------------------------------------------------------------
    // debounce
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            deb_cnt_q <= 32'h0;
            pressed_q <= 1'b0;
        end else if (pressed_q == pwr_btn_b) begin
            if (deb_cnt_q >= DEB_CYC - 1) begin
                deb_cnt_q <= 32'h0;
                pressed_q <= ~pwr_btn_b;
            end else begin
                deb_cnt_q <= deb_cnt_q + 32'h1;
            end
        end else begin
            deb_cnt_q <= 32'h0;
        end
    end

    // --------------------------------------------------------------
    // duration: long fires on crossing, short only at release
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt_q    <= 32'h0;
            press.short_p <= 1'b0;
            press.long_p  <= 1'b0;
        end else begin
            press.long_p  <= pressed_q && hold_cnt_q == LONG_CYC - 1;
            press.short_p <= !pressed_q && hold_cnt_q != 32'h0
                             && hold_cnt_q < LONG_CYC;
            if (!pressed_q) begin
                hold_cnt_q <= 32'h0;
            end else if (hold_cnt_q < LONG_CYC) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
        end
    end

endmodule

// File: design/pbw_top.sv
// power button and wake manager: sequencer, monitors and APB registers
// assumes all inputs synchronous to clk; APB master per AMBA rules
`timescale 1ns/1ps
module pbw_top #(
    parameter int unsigned DEB_CYC  = pbw_pkg::DEB_CYC,
    parameter int unsigned LONG_CYC = pbw_pkg::LONG_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // switch, wake and monitor inputs
    input  wire logic             pwr_btn_b,
    input  wire logic [6:0]       wake_req,
    input  wire logic             intrusion_closed,
    input  wire logic [4:0][7:0]  volt_rd,
    input  wire logic [2:0][7:0]  temp_rd,
    input  wire logic [7:0]       fw_prog,
    input  wire logic [5:0]       fw_err,
    // power control
    output pbw_pkg::pbw_state_t   pwr_state,
    output logic                  pwr_en,
    output logic                  cold_boot,
    output logic                  resume,
    output logic                  sys_rst,
    output logic      [2:0][7:0]  fan_duty,
    output logic                  irq
);

    pbw_press_if press ();

    pbw_pkg::pbw_state_t state_q, state_d;
    logic        cold_d, resume_d, rst_d, pend_q, pend_d;
    logic [2:0]  ctrl_q;
    logic [5:0]  istat_q, imask_q, ev;
    logic [13:0] fw_q;
    logic [4:0]  vflt_q;
    logic [15:0] fan_q;
    logic [15:0] vlim_q [5];
    logic [31:0] rdata_d;
    logic        hit_d, setup, wr, rd, cmd_go, rmt_go, wake_go, vsel, run;
    logic [7:0]  voff;

    pbw_press #(
        .DEB_CYC  (DEB_CYC),
        .LONG_CYC (LONG_CYC)
    ) u_press (
        .clk       (clk),
        .rst_b     (rst_b),
        .pwr_btn_b (pwr_btn_b),
        .press     (press)
    );

    // --------------------------------------------------------------
    // apb slave: no wait state; read data is registered in the setup cycle so it leaves a flop
    // --------------------------------------------------------------
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pready && pwrite;
    assign rd     = psel && penable && pready && !pwrite;
    assign voff   = paddr - pbw_pkg::ADDR_VLIM0;
    assign vsel   = paddr >= pbw_pkg::ADDR_VLIM0
                    && paddr <= pbw_pkg::ADDR_VLIMN && paddr[1:0] == 2'h0;
    assign cmd_go = wr && paddr == pbw_pkg::ADDR_CMD;
    assign rmt_go = wr && paddr == pbw_pkg::ADDR_RMT && |pwdata[3:0];
    assign run    = state_q == pbw_pkg::ST_S0 || state_q == pbw_pkg::ST_S1;

    always_comb begin
        rdata_d = 32'h0;
        hit_d   = 1'b1;
        if (vsel) begin
            rdata_d[15:0] = vlim_q[voff[4:2]];
        end else begin
            case (paddr)
                pbw_pkg::ADDR_CTRL:  rdata_d[2:0] = ctrl_q;
                pbw_pkg::ADDR_CMD, pbw_pkg::ADDR_RMT: rdata_d = 32'h0;
                pbw_pkg::ADDR_STATE: rdata_d[4:0] = {run, pend_q, state_q};
                pbw_pkg::ADDR_ISTAT: rdata_d[5:0] = istat_q;
                pbw_pkg::ADDR_IMASK: rdata_d[5:0] = imask_q;
                pbw_pkg::ADDR_FW:    rdata_d[13:0] = fw_q;
                pbw_pkg::ADDR_VFLT:  rdata_d[4:0] = vflt_q;
                pbw_pkg::ADDR_FAN:   rdata_d[15:0] = fan_q;
                default:             hit_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_d;
            if (setup) begin
                prdata <= rdata_d;
            end
        end
    end

    // --------------------------------------------------------------
    // writable configuration
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q  <= pbw_pkg::CTRL_RST;
            imask_q <= pbw_pkg::IMASK_RST;
            fan_q   <= pbw_pkg::FAN_RST;
        end else if (wr) begin
            if (paddr == pbw_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (paddr == pbw_pkg::ADDR_IMASK) begin
                imask_q <= pwdata[5:0];
            end
            if (paddr == pbw_pkg::ADDR_FAN) begin
                fan_q <= pwdata[15:0];
            end
        end
    end

    // --------------------------------------------------------------
    // supply window and fan loops, one instance per channel
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_volt
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    vlim_q[gi] <= pbw_pkg::VLIM_RST;
                    vflt_q[gi] <= 1'b0;
                end else begin
                    if (wr && vsel && voff[4:2] == 3'(gi)) begin
                        vlim_q[gi] <= pwdata[15:0];
                    end
                    vflt_q[gi] <= volt_rd[gi] < vlim_q[gi][7:0]
                                  || volt_rd[gi] > vlim_q[gi][15:8];
                end
            end
        end
        for (gi = 0; gi < 3; gi++) begin : g_fan
            // fans stay off outside S0/S1 whatever the temperature
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    fan_duty[gi] <= 8'h00;
                end else if (!run || temp_rd[gi] < fan_q[7:0]) begin
                    fan_duty[gi] <= 8'h00;
                end else if (temp_rd[gi] >= fan_q[15:8]) begin
                    fan_duty[gi] <= 8'hFF;
                end else begin
                    fan_duty[gi] <= temp_rd[gi];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // wake qualification per sleep state
    // --------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            pbw_pkg::ST_S1, pbw_pkg::ST_S3: wake_go = |wake_req;
            pbw_pkg::ST_S4: wake_go = |(wake_req & pbw_pkg::WAKE_DEEP);
            pbw_pkg::ST_S5:
                wake_go = |(wake_req & pbw_pkg::WAKE_S5)
                          || (ctrl_q[pbw_pkg::CTRL_S5EN]
                          && |(wake_req & pbw_pkg::WAKE_GATED));
            default: wake_go = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // sequencer: long press, remote, short press, wake, software
    // --------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        pend_d   = pend_q;
        rst_d    = 1'b0;
        if (press.long_p && state_q != pbw_pkg::ST_S5) begin
            state_d = pbw_pkg::ST_S5;
            pend_d  = 1'b0;
        end else if (rmt_go) begin
            if (pwdata[pbw_pkg::RMT_SHUT]) begin
                state_d = pbw_pkg::ST_S5;
            end else if (pwdata[pbw_pkg::RMT_CYCLE]) begin
                state_d = pbw_pkg::ST_S5;
                pend_d  = 1'b1;
            end else if (pwdata[pbw_pkg::RMT_UP]) begin
                state_d = pbw_pkg::ST_S0;
            end else begin
                rst_d = state_q == pbw_pkg::ST_S0;
            end
        end else if (pend_q && state_q == pbw_pkg::ST_S5) begin
            state_d = pbw_pkg::ST_S0;
            pend_d  = 1'b0;
        end else if (press.short_p) begin
            if (state_q != pbw_pkg::ST_S0) begin
                state_d = pbw_pkg::ST_S0;
            end else begin
                unique case (ctrl_q[2:1])
                    2'h0:    state_d = pbw_pkg::ST_S1;
                    2'h1:    state_d = pbw_pkg::ST_S3;
                    default: state_d = pbw_pkg::ST_S4;
                endcase
            end
        end else if (wake_go) begin
            state_d = pbw_pkg::ST_S0;
        end else if (cmd_go && state_q == pbw_pkg::ST_S0) begin
            unique case (pwdata[2:0])
                3'h1, 3'h3, 3'h4, 3'h5:
                    state_d = pbw_pkg::pbw_state_t'(pwdata[2:0]);
                default: state_d = state_q;
            endcase
        end
        cold_d   = state_d == pbw_pkg::ST_S0
                   && state_q == pbw_pkg::ST_S5;
        resume_d = state_d == pbw_pkg::ST_S0
                   && state_q != pbw_pkg::ST_S5
                   && state_q != pbw_pkg::ST_S0;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= pbw_pkg::ST_S5;
            pend_q    <= 1'b0;
            cold_boot <= 1'b0;
            resume    <= 1'b0;
            sys_rst   <= 1'b0;
            pwr_state <= pbw_pkg::ST_S5;
            pwr_en    <= 1'b0;
        end else begin
            state_q   <= state_d;
            pend_q    <= pend_d;
            cold_boot <= cold_d;
            resume    <= resume_d;
            sys_rst   <= rst_d || cold_d;
            pwr_state <= state_d;
            pwr_en    <= state_d == pbw_pkg::ST_S0
                         || state_d == pbw_pkg::ST_S1;
        end
    end

    // --------------------------------------------------------------
    // events: set beats the read-clear, only bits read are cleared
    // --------------------------------------------------------------
    always_comb begin
        ev               = 6'h00;
        ev[pbw_pkg::I_INTR] = intrusion_closed;
        ev[pbw_pkg::I_VOLT] = |vflt_q;
        ev[pbw_pkg::I_PROG] = |fw_prog;
        ev[pbw_pkg::I_ERR]  = |fw_err;
        ev[pbw_pkg::I_WAKE] = wake_go;
        ev[pbw_pkg::I_LONG] = press.long_p;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            istat_q <= 6'h00;
            fw_q    <= 14'h0000;
            irq     <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~((rd && paddr == pbw_pkg::ADDR_ISTAT)
                       ? prdata[5:0] : 6'h00)) | ev;
            fw_q    <= (fw_q & ~((rd && paddr == pbw_pkg::ADDR_FW)
                       ? prdata[13:0] : 14'h0000))
                       | {fw_err, fw_prog};
            irq     <= |(istat_q & imask_q);
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_long;
        press.long_p && state_q != pbw_pkg::ST_S5
            |=> state_q == pbw_pkg::ST_S5 ##1 !pwr_en;
    endproperty
    a_long: assert property (p_long) else $error("long press no off");
    property p_short_on;
        press.short_p && state_q == pbw_pkg::ST_S5 && !rmt_go && !pend_q
            |=> state_q == pbw_pkg::ST_S0 && cold_boot && sys_rst;
    endproperty
    a_short_on: assert property (p_short_on) else $error("no power on");
    property p_deep_wake;
        !press.long_p && !rmt_go && state_q == pbw_pkg::ST_S4
            && wake_req[3] |=> state_q == pbw_pkg::ST_S0 && resume;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("no wake");
    property p_light_only;
        state_q == pbw_pkg::ST_S4 && !press.long_p && !press.short_p
            && !rmt_go && (wake_req & pbw_pkg::WAKE_DEEP) == 7'h00
            |=> state_q == pbw_pkg::ST_S4;
    endproperty
    a_light_only: assert property (p_light_only) else $error("S4 woke");
    property p_s5_gate;
        state_q == pbw_pkg::ST_S5 && !ctrl_q[pbw_pkg::CTRL_S5EN]
            && !press.short_p && !rmt_go && !pend_q
            && (wake_req & pbw_pkg::WAKE_S5) == 7'h00
            |=> state_q == pbw_pkg::ST_S5;
    endproperty
    a_s5_gate: assert property (p_s5_gate) else $error("S5 gate open");
    property p_boot;
        state_q != pbw_pkg::ST_S0 ##1 state_q == pbw_pkg::ST_S0
            |-> cold_boot == ($past(state_q) == pbw_pkg::ST_S5)
                && resume != cold_boot;
    endproperty
    a_boot: assert property (p_boot) else $error("bad boot kind");
    property p_sw_only;
        state_q == pbw_pkg::ST_S0 && !cmd_go && !rmt_go
            && !press.short_p && !press.long_p
            |=> state_q == pbw_pkg::ST_S0;
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("stray exit");
    property p_intr;
        intrusion_closed |=> istat_q[pbw_pkg::I_INTR] ##1 irq
            || !imask_q[pbw_pkg::I_INTR];
    endproperty
    a_intr: assert property (p_intr) else $error("intrusion lost");
    property p_volt;
        volt_rd[0] > vlim_q[0][15:8] |=> vflt_q[0]
            ##1 istat_q[pbw_pkg::I_VOLT];
    endproperty
    a_volt: assert property (p_volt) else $error("volt not flagged");
    property p_fan_off;
        !run |=> fan_duty == 24'h000000;
    endproperty
    a_fan_off: assert property (p_fan_off) else $error("fan on asleep");
    property p_fw;
        fw_prog[7] && fw_err[0] |=> fw_q[7] && fw_q[pbw_pkg::FW_ERR];
    endproperty
    a_fw: assert property (p_fw) else $error("fw event lost");
    property p_rmt_shut;
        rmt_go && pwdata[pbw_pkg::RMT_SHUT] && !press.long_p
            |=> state_q == pbw_pkg::ST_S5 [*2];
    endproperty
    a_rmt_shut: assert property (p_rmt_shut) else $error("no shutdown");

    c_cold: cover property (state_q == pbw_pkg::ST_S5 ##1 cold_boot);
    c_long: cover property (press.long_p && state_q == pbw_pkg::ST_S3);
    c_cycle: cover property (pend_q ##1 state_q == pbw_pkg::ST_S0);

endmodule

// File: verification/pbw_far.sv
// far-side model: front panel power switch and wake sources
// assumes the bench calls one task at a time, right after an edge
`timescale 1ns/1ps
module pbw_far (
    // clock
    input  wire logic   clk,
    // switch and wake lines
    output logic        pwr_btn_b,
    output logic [6:0]  wake_req
);
    initial begin
        pwr_btn_b = 1'b1;
        wake_req  = 7'h00;
    end

    // switch held low for n cycles; no bounce, debounce still applies
    task automatic press(input int n);
        pwr_btn_b <= 1'b0;
        repeat (n) @(posedge clk);
        pwr_btn_b <= 1'b1;
    endtask

    // wake source asserted for two cycles, then idle low again
    task automatic wake(input logic [6:0] w);
        wake_req <= w;
        repeat (2) @(posedge clk);
        wake_req <= 7'h00;
    endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the power button and wake manager
// assumes pbw_far drives the switch and wake lines; APB master here
`timescale 1ns/1ps
module testbench;
    logic             clk, rst_b, psel, penable, pwrite;
    logic [7:0]       paddr, fw_prog;
    logic [31:0]      pwdata, prdata, seed, r;
    logic             pready, pslverr, pwr_btn_b, intrusion_closed;
    logic             pwr_en, cold_boot, resume, sys_rst, irq;
    logic [6:0]       wake_req;
    logic [5:0]       fw_err;
    logic [4:0][7:0]  volt_rd;
    logic [2:0][7:0]  temp_rd, fan_duty;
    logic [64:0]      nt;
    logic [64:0]      exp_q[$];
    pbw_pkg::pbw_state_t pwr_state;
    int               n_errors, total_checks, n_cold, n_res, n_rst;

    pbw_top #(.DEB_CYC(4), .LONG_CYC(40)) pbw_top_inst (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pwr_btn_b, .wake_req, .intrusion_closed,
        .volt_rd, .temp_rd, .fw_prog, .fw_err, .pwr_state, .pwr_en,
        .cold_boot, .resume, .sys_rst, .fan_duty, .irq);
    pbw_far pbw_far_inst (.clk, .pwr_btn_b, .wake_req);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        stop_test(1);
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [32:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test(input int bad);
        n_errors += bad;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // pulses are single cycles, so they are counted where they appear
    always @(posedge clk) begin
        if (cold_boot === 1'b1) n_cold++;
        if (resume === 1'b1) n_res++;
        if (sys_rst === 1'b1) n_rst++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = exp_q.pop_front();
            chk($sformatf("read %h", paddr), nt[32:0] & {1'b1, nt[64:33]},
                {pslverr, prdata} & {1'b1, nt[64:33]});
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) stop_test(1);
        {psel, penable} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
        exp_q.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic st(input logic [32:0] e);
        rd(pbw_pkg::ADDR_STATE, e);
        chk("pwr_state", e & 33'h7, 33'(pwr_state));
        chk("pwr_en", 33'(e[2:1] == 2'b00), 33'(pwr_en));
    endtask

    task automatic pr(input int n, input logic [32:0] e);
        pbw_far_inst.press(n);
        cyc(12);
        st(e);
    endtask

    task automatic wk(input logic [6:0] w, input logic [32:0] e);
        pbw_far_inst.wake(w);
        st(e);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {intrusion_closed, temp_rd, fw_prog, fw_err} = '0;
        seed = 32'h19;
        volt_rd = 40'({rnd(), rnd()});
        rst_b = 1'b0;
        cyc(12);
        rst_b <= 1'b1;
        rd(pbw_pkg::ADDR_CTRL, 33'h2);
        rd(pbw_pkg::ADDR_IMASK, 33'h0);
        rd(pbw_pkg::ADDR_FAN, 33'hC040);
        rd(pbw_pkg::ADDR_VLIMN, 33'hFF00);
        st(33'h5);
        rd(8'h3C, 33'h100000000);
        wr(pbw_pkg::ADDR_IMASK, 32'h3F);
        pr(15, 33'h10);
        chk("cold", 33'h1, 33'(n_cold));
        temp_rd <= {8'hD0, 8'h80, 8'h20};
        cyc(3);
        chk("fan", 33'hFF8000, 33'(fan_duty));
        rd(pbw_pkg::ADDR_ISTAT, 33'h0);
        cyc(3);
        chk("irq", 33'h0, 33'(irq));
        intrusion_closed <= 1'b1;
        cyc(3);
        intrusion_closed <= 1'b0;
        cyc(2);
        chk("irq", 33'h1, 33'(irq));
        rd(pbw_pkg::ADDR_ISTAT, 33'h1);
        wr(pbw_pkg::ADDR_VLIM0, 32'h8040);
        volt_rd[0] <= 8'h90;
        cyc(3);
        rd(pbw_pkg::ADDR_VFLT, 33'h1, 32'h1);
        rd(pbw_pkg::ADDR_ISTAT, 33'h2, 32'h2);
        volt_rd[0] <= 8'h3F;
        cyc(3);
        rd(pbw_pkg::ADDR_VFLT, 33'h1, 32'h1);
        volt_rd[0] <= 8'h40;
        cyc(3);
        rd(pbw_pkg::ADDR_VFLT, 33'h0, 32'h1);
        repeat (3) begin
            r = rnd() | 32'h180;
            {fw_err, fw_prog} <= r[13:0];
            @(posedge clk) {fw_err, fw_prog} <= 14'h0;
            rd(pbw_pkg::ADDR_FW, {19'h0, r[13:0]});
            rd(pbw_pkg::ADDR_FW, 33'h0);
            rd(pbw_pkg::ADDR_ISTAT, {29'h0, |r[13:8], |r[7:0], 2'b0},
               32'hC);
        end
        pr(15, 33'h3);
        chk("fan", 33'h0, 33'(fan_duty));
        wk(7'h10, 33'h10);
        wr(pbw_pkg::ADDR_CMD, 32'h4);
        st(33'h4);
        wk(7'h40, 33'h4);
        wk(7'h08, 33'h10);
        wr(pbw_pkg::ADDR_CMD, 32'h2);
        st(33'h10);
        chk("resume", 33'h2, 33'(n_res));
        wr(pbw_pkg::ADDR_CMD, 32'h5);
        wk(7'h01, 33'h5);
        wk(7'h20, 33'h5);
        wr(pbw_pkg::ADDR_CTRL, 32'h1);
        wk(7'h02, 33'h10);
        pr(15, 33'h11);
        pr(60, 33'h5);
        rd(pbw_pkg::ADDR_ISTAT, 33'h20, 32'h20);
        pr(15, 33'h10);
        pr(60, 33'h5);
        wr(pbw_pkg::ADDR_RMT, 32'h8);
        st(33'h10);
        wr(pbw_pkg::ADDR_RMT, 32'h1);
        wr(pbw_pkg::ADDR_RMT, 32'h2);
        st(33'h5);
        wr(pbw_pkg::ADDR_RMT, 32'h8);
        wr(pbw_pkg::ADDR_RMT, 32'h4);
        cyc(4);
        st(33'h10);
        chk("cold", 33'h6, 33'(n_cold));
        chk("reset", 33'h7, 33'(n_rst));
        stop_test(0);
    end
endmodule
